// ===== hw/pfc_core.v
// Program flow core: pointer, return stack, data RAM, accumulator, flags, table read.
// Assumes a synchronous program ROM that returns a word one cycle after its address,
// interrupt events as one-cycle pulses on this clock, and a classic Wishbone master.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_consts.vh"

module pfc_core #(
	parameter AW = 8
) (
	input  wire          mclk_i,
	input  wire          rst_i,
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [AW-1:0] wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	input  wire [4:0]    irq_evt_i,
	input  wire [15:0]   rom_data_i,
	output reg  [10:0]   rom_addr_o,
	output reg  [10:0]   pc_o,
	output reg  [4:0]    irq_ack_o
);

	// ======================================================================
	// Phase machine, one-hot.
	localparam [3:0] PH0 = 4'b0001;
	localparam [3:0] PH1 = 4'b0010;
	localparam [3:0] PH2 = 4'b0100;
	localparam [3:0] PH3 = 4'b1000;

	reg  [3:0]  ph_r;
	reg  [3:0]  ph_nxt;
	reg  [10:0] pc_nxt;
	reg  [2:0]  sp_r;
	reg  [10:0] stk_r [0:`PFC_STK_DEPTH-1];
	reg  [3:0]  ram_r [0:`PFC_RAM_WORDS-1];
	reg  [3:0]  acc_r;
	reg         cf_r;
	reg         zf_r;
	reg         err_r;
	reg  [3:0]  page_r;
	reg  [3:0]  table_addr_low_r;
	reg  [3:0]  table_addr_high_r;
	reg  [4:0]  pend_r;
	reg         ien_r;
	reg         cmd_pend_r;
	reg  [3:0]  cmd_op_r;
	reg  [10:0] cmd_arg_r;
	reg         act_r;
	reg         irq_r;
	reg  [3:0]  op_r;
	reg  [10:0] arg_r;
	reg  [10:0] vec_r;
	reg  [4:0]  grant_r;
	reg  [10:0] vec_sel;
	reg  [4:0]  grant_sel;
	reg  [1:0]  nib_r;
	reg  [3:0]  nib_val;
	reg  [6:0]  ea;
	reg         ram_we;
	reg  [3:0]  ram_wd;
	reg         push;
	reg         pop;
	reg  [10:0] push_val;
	reg  [3:0]  acc_nxt;
	reg         cf_nxt;
	reg         zf_nxt;
	reg         err_nxt;
	reg  [3:0]  page_nxt;
	reg  [3:0]  table_addr_low_nxt;
	reg  [3:0]  table_addr_high_nxt;
	wire        commit;
	wire        start_irq;
	wire        start_cmd;
	wire [3:0]  rd;
	wire [4:0]  sum5;
	wire [4:0]  dif5;
	wire [10:0] elem;
	wire [10:0] tab_word;
	wire        wb_req;
	wire        wb_wr;
	wire [AW-1:0] reg_adr;

	// Four clock phases form one machine cycle; the machine never stalls.
	always @* begin
		case (ph_r)
			PH0:     ph_nxt = PH1;
			PH1:     ph_nxt = PH2;
			PH2:     ph_nxt = PH3;
			PH3:     ph_nxt = PH0;
			default: ph_nxt = PH0;
		endcase
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			ph_r <= PH0;
		end else begin
			ph_r <= ph_nxt;
		end
	end

	// ======================================================================
	// Interrupt selection: fixed priority, lowest index wins.
	always @* begin
		vec_sel   = `PFC_VEC_DIV;
		grant_sel = 5'h01;
		if (pend_r[0]) begin
			vec_sel   = `PFC_VEC_DIV;
			grant_sel = 5'h01;
		end else if (pend_r[1]) begin
			vec_sel   = `PFC_VEC_TM0;
			grant_sel = 5'h02;
		end else if (pend_r[2]) begin
			vec_sel   = `PFC_VEC_CHG;
			grant_sel = 5'h04;
		end else if (pend_r[3]) begin
			vec_sel   = `PFC_VEC_EXT;
			grant_sel = 5'h08;
		end else begin
			vec_sel   = `PFC_VEC_TM1;
			grant_sel = 5'h10;
		end
	end

	// Interrupts are only taken at a cycle boundary and beat a waiting command.
	assign start_irq = (ph_r == PH0) && ien_r && (|pend_r);
	assign start_cmd = (ph_r == PH0) && !start_irq && cmd_pend_r;
	assign commit    = (ph_r == PH3);

	// ======================================================================
	// Operand fetch and datapath.
	// Indirect access joins the page bits with the low nibble of the argument.
	always @* begin
		if (op_r == `PFC_OP_LDI || op_r == `PFC_OP_STI) begin
			ea = {page_r[2:0], arg_r[3:0]};
		end else begin
			ea = arg_r[6:0];
		end
	end

	assign rd   = ram_r[ea];
	assign sum5 = {1'b0, acc_r} + {1'b0, rd};
	assign dif5 = {1'b0, acc_r} - {1'b0, rd};

	// Element address from both table registers and the accumulator.
	assign elem     = {table_addr_high_r[2:0], table_addr_low_r, acc_r};
	// Table data lives only in the top quarter of program memory.
	assign tab_word = `PFC_TAB_BASE + {2'b00, elem[10:2]};

	// Pick one of the four nibbles of the returned ROM word.
	always @* begin
		case (nib_r)
			2'd0:    nib_val = rom_data_i[3:0];
			2'd1:    nib_val = rom_data_i[7:4];
			2'd2:    nib_val = rom_data_i[11:8];
			default: nib_val = rom_data_i[15:12];
		endcase
	end

	// ======================================================================
	// Commit: every effect of an operation lands at the last phase.
	always @* begin
		pc_nxt   = pc_o;
		acc_nxt  = acc_r;
		cf_nxt   = cf_r;
		zf_nxt   = zf_r;
		err_nxt  = err_r;
		page_nxt = page_r;
		table_addr_low_nxt = table_addr_low_r;
		table_addr_high_nxt = table_addr_high_r;
		ram_we   = 1'b0;
		ram_wd   = acc_r;
		push     = 1'b0;
		pop      = 1'b0;
		push_val = pc_o + 11'd1;
		if (commit && irq_r) begin
			push     = 1'b1;
			push_val = pc_o;
			pc_nxt   = vec_r;
		end else if (commit && act_r) begin
			pc_nxt  = pc_o + 11'd1;
			err_nxt = 1'b0;
			case (op_r)
				`PFC_OP_JMP: pc_nxt = arg_r;
				`PFC_OP_CALL: begin
					push   = 1'b1;
					pc_nxt = arg_r;
				end
				`PFC_OP_RET: begin
					pop    = 1'b1;
					pc_nxt = stk_r[sp_r - 3'd1];
				end
				`PFC_OP_LDA, `PFC_OP_LDI: acc_nxt = rd;
				`PFC_OP_STA, `PFC_OP_STI: ram_we = 1'b1;
				`PFC_OP_ADD: begin
					acc_nxt = sum5[3:0];
					cf_nxt  = sum5[4];
					zf_nxt  = (sum5[3:0] == 4'h0);
				end
				`PFC_OP_SUB: begin
					acc_nxt = dif5[3:0];
					cf_nxt  = dif5[4];             // Borrow.
					zf_nxt  = (dif5[3:0] == 4'h0);
				end
				`PFC_OP_AND: begin
					acc_nxt = acc_r & rd;
					zf_nxt  = ((acc_r & rd) == 4'h0);
				end
				`PFC_OP_OR: begin
					acc_nxt = acc_r | rd;
					zf_nxt  = ((acc_r | rd) == 4'h0);
				end
				`PFC_OP_XOR: begin
					acc_nxt = acc_r ^ rd;
					zf_nxt  = ((acc_r ^ rd) == 4'h0);
				end
				`PFC_OP_MOVI: begin
					// General memory refuses immediates; only the error bit shows it.
					if (arg_r[6:0] < `PFC_WR_LIMIT) begin
						ram_we = 1'b1;
						ram_wd = arg_r[10:7];
					end else begin
						err_nxt = 1'b1;
					end
				end
				`PFC_OP_MISC: begin
					case (arg_r[10:8])
						`PFC_MS_TABLE_ADDR_LOW: table_addr_low_nxt = rd;
						`PFC_MS_TABLE_ADDR_HIGH: table_addr_high_nxt = rd;
						`PFC_MS_CARRY: begin
							ram_we = 1'b1;
							ram_wd = {3'b000, cf_r};
						end
						`PFC_MS_RLC: begin
							acc_nxt = {acc_r[2:0], cf_r};
							cf_nxt  = acc_r[3];
							zf_nxt  = ({acc_r[2:0], cf_r} == 4'h0);
						end
						`PFC_MS_RRC: begin
							acc_nxt = {cf_r, acc_r[3:1]};
							cf_nxt  = acc_r[0];
							zf_nxt  = ({cf_r, acc_r[3:1]} == 4'h0);
						end
						`PFC_MS_PGRD: acc_nxt = page_r;
						`PFC_MS_PGWR: page_nxt = acc_r;
						default: err_nxt = 1'b1;
					endcase
				end
				`PFC_OP_TBLRD: begin
					ram_we = 1'b1;
					ram_wd = nib_val;
				end
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Memories. The stack pointer wraps, so a ninth push replaces the oldest.
	always @(posedge mclk_i) begin
		if (ram_we) begin
			ram_r[ea] <= ram_wd;
		end
		if (push) begin
			stk_r[sp_r] <= push_val;
		end
	end

	always @(posedge mclk_i) begin
		if (rst_i) begin
			sp_r <= 3'd0;
		end else if (push) begin
			sp_r <= sp_r + 3'd1;
		end else if (pop) begin
			sp_r <= sp_r - 3'd1;
		end
	end

	// ======================================================================
	// Core state. Reset loads the start vector.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			pc_o       <= `PFC_RST_VEC;
			rom_addr_o <= `PFC_RST_VEC;
			acc_r      <= 4'h0;
			cf_r       <= 1'b0;
			zf_r       <= 1'b0;
			err_r      <= 1'b0;
			table_addr_low_r     <= 4'h0;
			table_addr_high_r     <= 4'h0;
			act_r      <= 1'b0;
			irq_r      <= 1'b0;
			op_r       <= `PFC_OP_NOP;
			arg_r      <= 11'h000;
			vec_r      <= `PFC_RST_VEC;
			grant_r    <= 5'h00;
			nib_r      <= 2'd0;
			irq_ack_o  <= 5'h00;
		end else begin
			pc_o      <= pc_nxt;
			acc_r     <= acc_nxt;
			cf_r      <= cf_nxt;
			zf_r      <= zf_nxt;
			err_r     <= err_nxt;
			table_addr_low_r    <= table_addr_low_nxt;
			table_addr_high_r    <= table_addr_high_nxt;
			irq_ack_o <= 5'h00;
			if (start_irq) begin
				irq_r     <= 1'b1;
				vec_r     <= vec_sel;
				grant_r   <= grant_sel;
				irq_ack_o <= grant_sel;
			end else if (start_cmd) begin
				act_r <= 1'b1;
				op_r  <= cmd_op_r;
				arg_r <= cmd_arg_r;
				nib_r <= elem[1:0];
				// The ROM answers a cycle later, well before the commit phase.
				if (cmd_op_r == `PFC_OP_TBLRD) begin
					rom_addr_o <= tab_word;
				end
			end else if (commit) begin
				act_r      <= 1'b0;
				irq_r      <= 1'b0;
				grant_r    <= 5'h00;
				rom_addr_o <= pc_nxt;
			end
		end
	end

	// ======================================================================
	// Wishbone slave: one wait-free answer the cycle after the strobe.
	assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
	assign reg_adr = {wb_adr_i[AW-1:2], 2'b00};

	always @(posedge mclk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h00000000;
			if (wb_req && !wb_we_i) begin
				case (reg_adr)
					`PFC_REG_CMD:  wb_dat_o <= {17'h0, cmd_arg_r, cmd_op_r};
					`PFC_REG_STAT: wb_dat_o <= {12'h000, err_r, zf_r, cf_r,
						cmd_pend_r | act_r | irq_r, 5'h00, pc_o};
					`PFC_REG_ACC:  wb_dat_o <= {28'h0000000, acc_r};
					`PFC_REG_PAGE: wb_dat_o <= {28'h0000000, 1'b0, page_r[2:0]};
					`PFC_REG_TAB:  wb_dat_o <= {24'h000000, table_addr_high_r, table_addr_low_r};
					`PFC_REG_IRQ:  wb_dat_o <= {23'h0, ien_r, 3'h0, pend_r};
					default:       wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Command slot: a write while an operation waits or runs is dropped.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			cmd_pend_r <= 1'b0;
			cmd_op_r   <= `PFC_OP_NOP;
			cmd_arg_r  <= 11'h000;
		end else if (wb_wr && reg_adr == `PFC_REG_CMD && wb_sel_i[1]
				&& !cmd_pend_r && !act_r) begin
			cmd_pend_r <= 1'b1;
			cmd_op_r   <= wb_dat_i[3:0];
			cmd_arg_r  <= wb_dat_i[`PFC_CMD_ARG_LSB+10:`PFC_CMD_ARG_LSB];
		end else if (start_cmd) begin
			cmd_pend_r <= 1'b0;
		end
	end

	// Page register: a core write of a value other than the current page takes the edge over a bus write.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			page_r <= `PFC_PAGE_RST;
		end else if (page_nxt != page_r) begin
			page_r <= {1'b0, page_nxt[2:0]};
		end else if (wb_wr && reg_adr == `PFC_REG_PAGE) begin
			page_r <= {1'b0, wb_dat_i[2:0]};      // Bit 3 is reserved.
		end
	end

	// Pending events are sticky; a new event beats its own clear by acceptance.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			pend_r <= 5'h00;
			ien_r  <= 1'b0;
		end else begin
			pend_r <= (pend_r & ~(start_irq ? grant_sel : 5'h00)) | irq_evt_i;
			if (start_irq) begin
				ien_r <= 1'b0;                    // Further entries wait for software.
			end else if (wb_wr && reg_adr == `PFC_REG_IRQ && wb_sel_i[1]) begin
				ien_r <= wb_dat_i[`PFC_IRQ_EN_BIT];
			end
		end
	end

endmodule
`default_nettype wire

// ===== pkg/pfc_consts.vh
// Constants of the program flow core: vectors, map sizes, bus offsets, opcodes.
// Assumes inclusion by bare name from the core and the bench files.
// ======================================================================
// Operation
// - An 11-bit instruction pointer addresses the 2048-word program memory.
// - Jumps, calls, accepted interrupts and reset load the pointer with their target.
// - Reset starts at 000H; vectors 004H, 008H, 00CH, 014H, 020H per source.
// - Pending interrupts are served divider, timer one, port, pin, timer two.
// - An 11-bit eight-level return stack; calls and interrupts push the pointer.
// - The return operation pops the top entry into the instruction pointer.
// - A ninth push overwrites the oldest entry; eight newest always kept.
// - 000H-5FFH hold code only; 600H-7FFH hold code and table data.
// - Lookup table holds up to 2048 separately addressed 4-bit elements.
// - Table read uses high, low table registers and accumulator; result to RAM.
// - Table address registers change only through their move-from-RAM operations.
// - Data memory is 128 nibbles reachable directly and indirectly.
// - Locations 00H-0FH are working registers; others refuse immediate data.
// - Page register is 4 bits, bit 3 reserved; bits 2-0 pick indirect page.
// - The page register is readable and writable by program operations.
// - A 4-bit accumulator takes results and moves data between places.
// - Logic, test, shift and add/subtract update carry and zero; carry movable. Logic operations here update zero only and keep carry.
// - One machine cycle spans four clock phases.
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
// ======================================================================
// Program map
`define PFC_PC_W        11
`define PFC_RST_VEC     11'h000
`define PFC_VEC_DIV     11'h004
`define PFC_VEC_TM0     11'h008
`define PFC_VEC_CHG     11'h00C
`define PFC_VEC_EXT     11'h014
`define PFC_VEC_TM1     11'h020
`define PFC_TAB_BASE    11'h600
`define PFC_STK_DEPTH   8
`define PFC_RAM_WORDS   128
`define PFC_WR_LIMIT    7'h10
`define PFC_PAGE_RST    4'h0
`define PFC_PHASES      4
// ======================================================================
// Register word offsets on the bus
`define PFC_REG_CMD     8'h00
`define PFC_REG_STAT    8'h04
`define PFC_REG_ACC     8'h08
`define PFC_REG_PAGE    8'h0C
`define PFC_REG_TAB     8'h10
`define PFC_REG_IRQ     8'h14
`define PFC_CMD_ARG_LSB 4
`define PFC_IRQ_EN_BIT  8
// ======================================================================
// Operation codes
`define PFC_OP_NOP      4'h0
`define PFC_OP_JMP      4'h1
`define PFC_OP_CALL     4'h2
`define PFC_OP_RET      4'h3
`define PFC_OP_LDA      4'h4
`define PFC_OP_STA      4'h5
`define PFC_OP_LDI      4'h6
`define PFC_OP_STI      4'h7
`define PFC_OP_ADD      4'h8
`define PFC_OP_SUB      4'h9
`define PFC_OP_AND      4'hA
`define PFC_OP_OR       4'hB
`define PFC_OP_XOR      4'hC
`define PFC_OP_MOVI     4'hD
`define PFC_OP_MISC     4'hE
`define PFC_OP_TBLRD    4'hF
// Sub-functions of the misc operation.
`define PFC_MS_TABLE_ADDR_LOW     3'h0
`define PFC_MS_TABLE_ADDR_HIGH     3'h1
`define PFC_MS_CARRY    3'h2
`define PFC_MS_RLC      3'h3
`define PFC_MS_RRC      3'h4
`define PFC_MS_PGRD     3'h5
`define PFC_MS_PGWR     3'h6
`endif

// ===== test/pfc_core_checker.sv
// Checker of the program flow core ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module pfc_core_checker #(
	parameter AW = 8
) (
	input wire logic          mclk_i,
	input wire logic          rst_i,
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [3:0]    wb_sel_i,
	input wire logic [31:0]   wb_dat_i,
	input wire logic [31:0]   wb_dat_o,
	input wire logic          wb_ack_o,
	input wire logic [4:0]    irq_evt_i,
	input wire logic [15:0]   rom_data_i,
	input wire logic [10:0]   rom_addr_o,
	input wire logic [10:0]   pc_o,
	input wire logic [4:0]    irq_ack_o
);
// ======================================================================
// Vector of the last accepted source, held so the pointer check may lag.
logic [10:0] vec_r;
logic [10:0] vec_nxt;
assign vec_nxt = irq_ack_o[0] ? 11'h004 : irq_ack_o[1] ? 11'h008 :
	irq_ack_o[2] ? 11'h00C : irq_ack_o[3] ? 11'h014 : irq_ack_o[4] ? 11'h020 : vec_r;
always_ff @(posedge mclk_i) begin
	vec_r <= vec_nxt;
end
// ======================================================================
// Properties
AST_ACK_NEXT: assert property (@(posedge mclk_i) disable iff (rst_i)
	wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
AST_ACK_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
	wb_ack_o |=> !wb_ack_o) else $error("ack too long");
AST_DAT_IDLE: assert property (@(posedge mclk_i) disable iff (rst_i)
	!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
AST_RST_STATE: assert property (@(posedge mclk_i)
	rst_i |=> pc_o == 11'h000 && rom_addr_o == 11'h000 && !wb_ack_o) else $error("reset state");
AST_PTR_READ: assert property (@(posedge mclk_i) disable iff (rst_i)
	wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h01 |-> wb_dat_o[10:0] == $past(pc_o))
	else $error("status pointer");
AST_IRQ_ONEHOT: assert property (@(posedge mclk_i) disable iff (rst_i)
	irq_ack_o != 5'h00 |-> $onehot(irq_ack_o)) else $error("two accepts");
AST_IRQ_VEC: assert property (@(posedge mclk_i) disable iff (rst_i)
	irq_ack_o != 5'h00 |=> ##[0:3] pc_o == vec_r) else $error("vector");
AST_IRQ_GAP: assert property (@(posedge mclk_i) disable iff (rst_i)
	irq_ack_o != 5'h00 |=> (irq_ack_o == 5'h00) [*3]) else $error("accepts too close");
endmodule
bind pfc_core pfc_core_checker #(.AW(AW)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_evt_i(irq_evt_i), .rom_data_i(rom_data_i), .rom_addr_o(rom_addr_o),
	.pc_o(pc_o), .irq_ack_o(irq_ack_o));
`default_nettype wire

// ===== test/pfc_rom_model.sv
// Program ROM model: a registered read of one word.
// Assumes the core holds the word address for one clock.
`timescale 1ns/100ps
`default_nettype none
module pfc_rom_model (
	input  wire logic        mclk_i,
	input  wire logic [10:0] rom_addr_i,
	output logic      [15:0] rom_data_o
);
// ======================================================================
// Contents
// Lanes 0 and 3 of a word always differ, so a wrong choice between them shows up.
function automatic logic [15:0] rom_word(input logic [10:0] a);
	return {a[3:0] ^ 4'h3, a[7:4] ^ 4'h6, 1'b1, a[10:8], a[3:0] ^ 4'h9};
endfunction
// The word follows the address one clock later, as a real array would.
always @(posedge mclk_i) begin
	rom_data_o <= rom_word(rom_addr_i);
end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench of the program flow core over its register bus.
// Assumes the ROM model beside the core and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_consts.vh"
module tb;
// ======================================================================
// Signals and scoreboard
logic        mclk_i = 1'b0;
logic        rst_i = 1'b1;
logic        wb_cyc_i = 1'b0;
logic        wb_stb_i = 1'b0;
logic        wb_we_i = 1'b0;
logic [7:0]  wb_adr_i = 8'h00;
logic [3:0]  wb_sel_i = 4'h0;
logic [31:0] wb_dat_i = 32'h0;
logic [31:0] wb_dat_o;
logic        wb_ack_o;
logic [4:0]  irq_evt_i = 5'h00;
logic [15:0] rom_data_i;
logic [10:0] rom_addr_o;
logic [10:0] pc_o;
logic [4:0]  irq_ack_o;
logic [31:0] exp_q[$];
logic [31:0] msk_q[$];
logic [10:0] stk[$];
logic [10:0] pc_m = 11'h000;
logic [31:0] lfsr = 32'h221FEF84;
int          num_errors = 0;
int          check_count = 0;
always #20 mclk_i = ~mclk_i;
pfc_core u_pfc_core (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_evt_i(irq_evt_i),
	.rom_data_i(rom_data_i), .rom_addr_o(rom_addr_o), .pc_o(pc_o), .irq_ack_o(irq_ack_o));
pfc_rom_model u_pfc_rom_model (.mclk_i(mclk_i), .rom_addr_i(rom_addr_o),
	.rom_data_o(rom_data_i));
// ======================================================================
// Helpers
task automatic fail(input string m);
	num_errors++;
	$display("unexpected at %0t: %s", $time, m);
endtask
task automatic rnd(output logic [3:0] v);
	lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	v = lfsr[3:0];
endtask
// One classic cycle; the request stands until ack is seen at an edge.
task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
	int n;
	n = 0;
	wb_adr_i <= a;
	wb_we_i <= w;
	wb_dat_i <= d;
	wb_sel_i <= 4'hF;
	wb_cyc_i <= 1'b1;
	wb_stb_i <= 1'b1;
	@(posedge mclk_i);
	while (wb_ack_o !== 1'b1 && n < 20) begin
		@(posedge mclk_i);
		n++;
	end
	if (n == 20) fail("no ack");
	wb_cyc_i <= 1'b0;
	wb_stb_i <= 1'b0;
	@(posedge mclk_i);
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
	exp_q.push_back(e & m);
	msk_q.push_back(m);
	bus(a, 1'b0, 32'h0);
endtask
task automatic push(input logic [10:0] v);
	stk.push_back(v);
	if (stk.size() > 8) void'(stk.pop_front());
endtask
// A command is followed by a wait longer than its longest latency.
task automatic cmd(input logic [3:0] op, input logic [10:0] arg);
	bus(`PFC_REG_CMD, 1'b1, {17'h0, arg, op});
	case (op)
		`PFC_OP_JMP: pc_m = arg;
		`PFC_OP_CALL: begin
			push(pc_m + 11'h001);
			pc_m = arg;
		end
		`PFC_OP_RET: pc_m = stk.pop_back();
		default: pc_m = pc_m + 11'h001;
	endcase
	repeat (9) @(posedge mclk_i);
endtask
task automatic set_acc(input logic [3:0] v);
	cmd(`PFC_OP_MOVI, {v, 7'h01});
	cmd(`PFC_OP_LDA, 11'h001);
endtask
task automatic finish_test;
	$display("errors %0d checks %0d", num_errors, check_count);
	if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
endtask
// ======================================================================
// Read answers are matched against the oldest note.
always @(posedge mclk_i) begin
	if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
		check_count++;
		if (exp_q.size() == 0) fail("read without a note");
		else begin
			if ((wb_dat_o & msk_q[0]) !== exp_q[0]) fail($sformatf("adr %h got %h", wb_adr_i, wb_dat_o));
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
end
initial begin
	repeat (5000) @(posedge mclk_i);
	fail("watchdog");
	finish_test();
end
// ======================================================================
// Main sequence
initial begin
	logic [3:0]  v;
	logic [3:0]  th;
	logic [3:0]  tl;
	logic [10:0] el;
	logic [15:0] w;
	logic [10:0] vecs[5];
	vecs = '{`PFC_VEC_DIV, `PFC_VEC_TM0, `PFC_VEC_CHG, `PFC_VEC_EXT, `PFC_VEC_TM1};
	repeat (12) @(posedge mclk_i);
	rst_i <= 1'b0;
	@(posedge mclk_i);
	rd(`PFC_REG_STAT, 32'h0, 32'h000F07FF);
	rd(`PFC_REG_ACC, 32'h0, 32'hF);
	rd(`PFC_REG_PAGE, 32'h0, 32'hF);
	rd(8'h18, 32'h0, 32'hFFFFFFFF);
	$display("reset test done");
	for (int i = 0; i < 4; i++) begin
		rnd(v);
		bus(`PFC_REG_PAGE, 1'b1, {28'h0, v[3], 3'(2 * i + 1)});
		rd(`PFC_REG_PAGE, {29'h0, 3'(2 * i + 1)}, 32'hF);
		set_acc(v);
		cmd(`PFC_OP_STI, 11'h005);
		set_acc(~v);
		cmd(`PFC_OP_LDA, {4'h0, 3'(2 * i + 1), 4'h5});
		rd(`PFC_REG_ACC, {28'h0, v}, 32'hF);
	end
	$display("page test done");
	cmd(`PFC_OP_MOVI, {4'h6, 7'h10});
	rd(`PFC_REG_STAT, {13'h1, 8'h00, pc_m}, 32'h000807FF);
	cmd(`PFC_OP_MOVI, {4'h6, 7'h0F});
	rd(`PFC_REG_STAT, {21'h0, pc_m}, 32'h000807FF);
	cmd(`PFC_OP_MOVI, {4'hA, 7'h02});
	cmd(`PFC_OP_MOVI, {4'h0, 7'h03});
	set_acc(4'h7);
	cmd(`PFC_OP_ADD, 11'h002);
	rd(`PFC_REG_STAT, 32'h20000, 32'h60000);
	rd(`PFC_REG_ACC, 32'h1, 32'hF);
	cmd(`PFC_OP_XOR, 11'h002);
	rd(`PFC_REG_ACC, 32'hB, 32'hF);
	cmd(`PFC_OP_AND, 11'h003);
	rd(`PFC_REG_STAT, 32'h60000, 32'h60000);
	cmd(`PFC_OP_MISC, {3'h2, 8'h08});
	cmd(`PFC_OP_LDA, 11'h008);
	rd(`PFC_REG_ACC, 32'h1, 32'hF);
	// Subtract borrows, OR keeps carry, rotates run through carry.
	cmd(`PFC_OP_SUB, 11'h002);
	rd(`PFC_REG_STAT, 32'h20000, 32'h60000);
	rd(`PFC_REG_ACC, 32'h7, 32'hF);
	cmd(`PFC_OP_OR, 11'h003);
	cmd(`PFC_OP_MISC, {3'h3, 8'h00});
	rd(`PFC_REG_ACC, 32'hF, 32'hF);
	rd(`PFC_REG_STAT, 32'h0, 32'h60000);
	cmd(`PFC_OP_MISC, {3'h4, 8'h00});
	// Program writes and reads of the page register, and a direct store.
	cmd(`PFC_OP_STA, 11'h009);
	cmd(`PFC_OP_MISC, {3'h6, 8'h00});
	rd(`PFC_REG_PAGE, 32'h7, 32'hF);
	cmd(`PFC_OP_XOR, 11'h009);
	rd(`PFC_REG_STAT, 32'h60000, 32'h60000);
	cmd(`PFC_OP_MISC, {3'h5, 8'h00});
	rd(`PFC_REG_ACC, 32'h7, 32'hF);
	$display("alu test done");
	for (int i = 0; i < 2; i++) begin
		rnd(th);
		rnd(tl);
		rnd(v);
		cmd(`PFC_OP_MOVI, {tl, 7'h06});
		cmd(`PFC_OP_MOVI, {th, 7'h07});
		cmd(`PFC_OP_MISC, {3'h0, 8'h06});
		cmd(`PFC_OP_MISC, {3'h1, 8'h07});
		set_acc(v);
		cmd(`PFC_OP_TBLRD, 11'h004);
		cmd(`PFC_OP_LDA, 11'h004);
		el = {th[2:0], tl, v};
		w = u_pfc_rom_model.rom_word(11'h600 + {2'b00, el[10:2]});
		rd(`PFC_REG_ACC, {28'h0, 4'(w >> {el[1:0], 2'b00})}, 32'hF);
		rd(`PFC_REG_TAB, {24'h0, th, tl}, 32'hFF);
	end
	$display("table test done");
	cmd(`PFC_OP_NOP, 11'h000);
	for (int i = 0; i < 9; i++) cmd(`PFC_OP_CALL, 11'h100 + 11'(16 * i));
	rd(`PFC_REG_STAT, {21'h0, pc_m}, 32'h7FF);
	for (int i = 0; i < 8; i++) begin
		cmd(`PFC_OP_RET, 11'h000);
		rd(`PFC_REG_STAT, {21'h0, pc_m}, 32'h7FF);
	end
	cmd(`PFC_OP_JMP, 11'h7F0);
	rd(`PFC_REG_STAT, {21'h0, pc_m}, 32'h7FF);
	$display("stack test done");
	irq_evt_i <= 5'h1F;
	@(posedge mclk_i);
	irq_evt_i <= 5'h00;
	repeat (8) @(posedge mclk_i);
	rd(`PFC_REG_IRQ, 32'h01F, 32'h11F);
	for (int k = 0; k < 5; k++) begin
		bus(`PFC_REG_IRQ, 1'b1, 32'h100);
		repeat (9) @(posedge mclk_i);
		push(pc_m);
		pc_m = vecs[k];
		rd(`PFC_REG_STAT, {21'h0, pc_m}, 32'h7FF);
	end
	rd(`PFC_REG_IRQ, 32'h0, 32'h11F);
	cmd(`PFC_OP_RET, 11'h000);
	rd(`PFC_REG_STAT, {21'h0, pc_m}, 32'h7FF);
	$display("interrupt test done");
	finish_test();
end
endmodule
`default_nettype wire
